/* File: dv/sprm_line_model.sv */
// Purpose: line side model, optics alarm levels, framer status and event strobes
// Assumes: bench requests change right after a rising edge
// Notes:   every output moves only at a rising edge, one clock after its request
`timescale 1ns/1ps

module sprm_line_model (
   input  wire logic       clock,   // system clock
   input  wire logic       rstn,    // sync reset, active low
   input  wire logic [5:0] lv_req,  // alarm levels asked for by the bench
   input  wire logic [7:0] ev_req,  // event strobes asked for by the bench
   input  wire logic [7:0] lbl_req, // label octet asked for by the bench
   output logic      [5:0] lv_pin,  // cdr, power, no signal, no clock, unlock, no pointer
   output logic      [7:0] ev_pin,  // crc, good, rx fifo, tx fifo, section, line, path, link
   output logic      [7:0] lbl_pin  // received label octet
);
   // ------------------------------------------------------------
   // alarm levels
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn) lv_pin <= 6'h00;
      else lv_pin <= lv_req;
   end

   // ------------------------------------------------------------
   // event strobes and label, same clock as the monitor
   // ------------------------------------------------------------
   // one request cycle gives exactly one strobe cycle, so counts stay exact
   always_ff @(posedge clock) begin
      if (!rstn) ev_pin <= 8'h00;
      else ev_pin <= ev_req;
   end

   always_ff @(posedge clock) begin
      if (!rstn) lbl_pin <= 8'h00;
      else lbl_pin <= lbl_req;
   end
endmodule

/* File: dv/sprm_monitor_bench.sv */
// Purpose: self-checking bench of the receive status monitor
// Assumes: AXI4-Lite master in the bench, line side in sprm_line_model
// Notes:   sync loss count shortened; saturation at all ones is out of reach here
`timescale 1ns/1ps
`include "sprm_map.svh"

module sprm_monitor_bench;
   import sprm_pkg::*;
   localparam int       SYNC_CNT = 20;
   localparam logic [1:0] OK  = `SPRM_RESP_OKAY;
   localparam logic [1:0] ERR = `SPRM_RESP_SLV;
   localparam logic [7:0] FBIT [6] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h80};
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [5:0]  lv_req = 6'h00;
   logic [7:0]  ev_req = 8'h00;
   logic [7:0]  lbl_req = 8'h00;
   wire logic [5:0] lv_pin, fl;
   wire logic [7:0] ev_pin, lbl_pin, label_out;
   wire logic   rx_alarm, sync_lost, irq;
   int          mismatches = 0;
   int          num_checks = 0;

   always #12.5 clock = ~clock;

   sprm_line_model sprm_line_model_inst (.clock(clock), .rstn(rstn), .lv_req(lv_req),
      .ev_req(ev_req), .lbl_req(lbl_req), .lv_pin(lv_pin), .ev_pin(ev_pin), .lbl_pin(lbl_pin));

   sprm_monitor #(.SYNC_LOSS_CYCLES(SYNC_CNT)) sprm_monitor_inst (.clock(clock), .rstn(rstn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .optics_cdr_pin(lv_pin[0]), .optics_pwr_pin(lv_pin[1]), .framer_nosig_pin(lv_pin[2]),
      .framer_noclk_pin(lv_pin[3]), .framer_unlock_pin(lv_pin[4]), .framer_noptr_pin(lv_pin[5]),
      .crc_fail_ev(ev_pin[0]), .frame_ok_ev(ev_pin[1]), .rx_fifo_err_ev(ev_pin[2]),
      .tx_fifo_err_ev(ev_pin[3]), .section_bip_ev(ev_pin[4]), .line_bip_ev(ev_pin[5]),
      .path_bip_ev(ev_pin[6]), .link_parity_ev(ev_pin[7]), .label_in(lbl_pin),
      .optics_rx_alarm(rx_alarm), .optics_cdr_fail(fl[0]), .optics_power_low(fl[1]),
      .no_signal_flag(fl[2]), .recovered_clk_absent(fl[3]), .frame_unlocked(fl[4]),
      .frame_sync_lost(sync_lost), .pointer_lost(fl[5]), .path_signal_label_octet(label_out),
      .irq(irq));

   // ------------------------------------------------------------
   // report and bus tasks
   // ------------------------------------------------------------
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic hang(input string what);
      mismatches++;
      $display("MISMATCH %0t no answer on %s", $time, what);
      end_of_test();
   endtask

   // tasks are entered right after a rising edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
      if (!done) hang("write");
      @(posedge clock);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er,
                         input string what);
      bit done;
      done = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 50 && !done; n++) begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            chk(rdata, exp, what);
            chk(rresp, er, what);
            rready <= 1'b0;
            done = 1;
         end
      end
      if (!done) hang("read");
      @(posedge clock);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_bus;
      logic [1:0] r;
      rd_chk(`SPRM_MASK_OFS, 32'h0, OK, "mask reset");
      rd_chk(`SPRM_STICKY_OFS, 32'h0, OK, "sticky reset");
      chk(irq, 1'b0, "irq reset");
      axi_wr(`SPRM_MASK_OFS, 32'hFFFF_FFFF, r);
      chk(r, OK, "mask write");
      rd_chk(`SPRM_MASK_OFS, 32'h0000_00FF, OK, "mask readback");
      axi_wr(`SPRM_MASK_OFS, 32'h0, r);
      axi_wr(`SPRM_LIVE_OFS, 32'hFF, r);
      chk(r, OK, "live write");
      axi_wr(8'h40, 32'h1, r);
      chk(r, ERR, "unmapped write");
      rd_chk(8'h30, 32'h0, ERR, "unmapped read");
      rd_chk(8'h02, 32'h0, ERR, "misaligned read");
   endtask

   task automatic t_flags;
      logic [1:0] r;
      logic [7:0] e;
      for (int i = 0; i < 6; i++) begin
         e = FBIT[i] | ((i < 2) ? 8'h01 : 8'h00);
         lv_req[i] <= 1'b1;
         repeat (2) @(posedge clock);
         #1 chk(fl[i], 1'b0, "flag early");
         @(posedge clock);
         #1 chk(fl[i], 1'b1, "flag on");
         chk(rx_alarm, (i < 2), "summary alarm");
         @(posedge clock);
         rd_chk(`SPRM_LIVE_OFS, {24'h0, e}, OK, "live");
         lv_req[i] <= 1'b0;
         repeat (4) @(posedge clock);
         chk(irq, 1'b0, "masked irq");
         rd_chk(`SPRM_STICKY_OFS, {24'h0, e}, OK, "sticky held");
         axi_wr(`SPRM_STICKY_OFS, 32'hFF, r);
         rd_chk(`SPRM_STICKY_OFS, 32'h0, OK, "sticky cleared");
      end
   endtask

   task automatic t_sync_loss;
      logic [1:0] r;
      int n;
      axi_wr(`SPRM_MASK_OFS, 32'h40, r);
      lv_req[4] <= 1'b1;
      repeat (SYNC_CNT - 5) begin
         @(posedge clock);
         chk(sync_lost, 1'b0, "short episode");
      end
      lv_req[4] <= 1'b0;
      repeat (6) @(posedge clock);
      chk(irq, 1'b0, "no sync loss irq");
      lv_req[4] <= 1'b1;
      for (n = 0; n < SYNC_CNT + 20 && sync_lost !== 1'b1; n++) @(posedge clock);
      chk(n >= SYNC_CNT + 3 && n <= SYNC_CNT + 7, 1'b1, "sync loss delay");
      if (sync_lost !== 1'b1) hang("sync loss");
      repeat (2) @(posedge clock);
      chk(irq, 1'b1, "sync loss irq");
      lv_req[4] <= 1'b0;
      repeat (5) @(posedge clock);
      chk(sync_lost, 1'b0, "sync loss falls");
      axi_wr(`SPRM_STICKY_OFS, 32'h40, r);
      repeat (2) @(posedge clock);
      chk(irq, 1'b0, "irq cleared");
      axi_wr(`SPRM_MASK_OFS, 32'h0, r);
      axi_wr(`SPRM_STICKY_OFS, 32'hFF, r);
   endtask

   task automatic t_counters;
      logic [7:0] a;
      for (int c = 0; c < 8; c++) begin
         a = `SPRM_CNT_BASE_OFS + 8'(4 * c);
         ev_req[c] <= 1'b1;
         repeat (c + 1) @(posedge clock);
         ev_req[c] <= 1'b0;
         @(posedge clock);
         ev_req[c] <= 1'b1;
         @(posedge clock);
         ev_req[c] <= 1'b0;
         repeat (4) @(posedge clock);
         rd_chk(a, c + 2, OK, "count");
         rd_chk(a, 32'h0, OK, "count after read");
      end
   endtask

   task automatic t_label;
      logic [7:0] v [2] = '{8'h16, 8'hCF};
      for (int k = 0; k < 2; k++) begin
         lbl_req <= v[k];
         repeat (3) @(posedge clock);
         chk(label_out, v[k], "label out");
         rd_chk(`SPRM_LABEL_OFS, {24'h0, v[k]}, OK, "label reg");
      end
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      t_bus();
      t_flags();
      t_sync_loss();
      t_counters();
      t_label();
      end_of_test();
   end
endmodule

/* File: inc/sprm_map.svh */
// Purpose: offsets, bit positions, reset values and timing counts
//          of the receive status monitor
// Assumes: 40 MHz system clock, AXI4-Lite byte addresses
// Notes:   definitions only
//
// Overview of operation
// - frame_sync_lost rises only after frame_unlocked holds longer than 3 ms.
// - frame_unlocked high while framer lacks frame lock, low once aligned.
// - pointer_lost high while framer cannot lock to payload pointers.
// - no_signal_flag high for absent or unrecognisably weak receive signal.
// - recovered_clk_absent high while optics deliver no valid clock.
// - optics_rx_alarm summarises optics errors; cdr or power bit always accompanies it.
// - optics_cdr_fail follows the optics clock recovery failure signal.
// - optics_power_low follows the optics low power signal, below -30dBm.
// - crc_fail_count counts CRC32 failed frames since last read.
// - frames_ok_count counts received frames since last read.
// - rx_fifo_error_count counts framer receive FIFO errors since last read.
// - tx_fifo_error_count counts framer transmit FIFO errors since last read.
// - sticky bits and counters accumulate between reads, spans may exceed one poll.
// - section_parity_errors counts first parity check errors.
// - line_parity_errors counts second parity check errors.
// - path_parity_errors counts third parity check errors.
// - path_signal_label_octet shows the received label unchanged; 16 PoS, CF HDLC.
// - framer_link_parity_errors counts framer-to-capture data path parity errors.
`ifndef SPRM_MAP_SVH
`define SPRM_MAP_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SPRM_LIVE_OFS     8'h00
`define SPRM_STICKY_OFS   8'h04
`define SPRM_MASK_OFS     8'h08
`define SPRM_LABEL_OFS    8'h0C
`define SPRM_CNT_BASE_OFS 8'h10
`define SPRM_CNT_LAST_OFS 8'h2C

// ------------------------------------------------------------
// flag bit positions, shared by live, sticky and mask
// ------------------------------------------------------------
`define SPRM_B_RX_ALARM  0
`define SPRM_B_CDR_FAIL  1
`define SPRM_B_PWR_LOW   2
`define SPRM_B_NO_SIG    3
`define SPRM_B_NO_CLK    4
`define SPRM_B_UNLOCKED  5
`define SPRM_B_SYNC_LOST 6
`define SPRM_B_PTR_LOST  7

// ------------------------------------------------------------
// reset values, responses, timing
// ------------------------------------------------------------
`define SPRM_MASK_RST   8'h00
`define SPRM_RESP_OKAY  2'h0
`define SPRM_RESP_SLV   2'h2
`define SPRM_SYNC_LOSS_US     3000
`define SPRM_CLK_MHZ          40
`define SPRM_SYNC_LOSS_CYCLES (`SPRM_SYNC_LOSS_US * `SPRM_CLK_MHZ)

`endif

/* File: inc/sprm_pkg.sv */
// Purpose: types of the receive status monitor
// Assumes: constants come from sprm_map.svh
// Notes:   counter order equals register order
package sprm_pkg;
   typedef logic [31:0] sprm_word_type;
   typedef logic [7:0]  sprm_flags_type;
   typedef enum logic [2:0] {
      SPRM_CRC, SPRM_GOOD, SPRM_RX_FIFO, SPRM_TX_FIFO,
      SPRM_SEC, SPRM_LINE, SPRM_PATH, SPRM_LINK
   } sprm_cnt_type;
endpackage

/* File: rtl/sprm_monitor.sv */
// Purpose: receive status and statistics monitor of a packet-over-SONET
//          framer, read by software over AXI4-Lite
// Assumes: alarm pins are asynchronous; event strobes and the label come
//          from framer interface logic on this clock
// Notes:   counters clear on read, flags are sticky until write-one-clear
`timescale 1ns/1ps
`include "sprm_map.svh"

module sprm_monitor
   import sprm_pkg::*;
#(
   parameter int unsigned SYNC_LOSS_CYCLES = `SPRM_SYNC_LOSS_CYCLES
) (
   input  wire logic        clock,                // 40 MHz system clock
   input  wire logic        rstn,                 // sync reset, active low
   input  wire logic [7:0]  s_axi_awaddr,         // write address
   input  wire logic        s_axi_awvalid,        // write address valid
   output logic             s_axi_awready,        // write address ready
   input  wire logic [31:0] s_axi_wdata,          // write data
   input  wire logic [3:0]  s_axi_wstrb,          // write byte enables
   input  wire logic        s_axi_wvalid,         // write data valid
   output logic             s_axi_wready,         // write data ready
   output logic [1:0]       s_axi_bresp,          // write response
   output logic             s_axi_bvalid,         // write response valid
   input  wire logic        s_axi_bready,         // write response ready
   input  wire logic [7:0]  s_axi_araddr,         // read address
   input  wire logic        s_axi_arvalid,        // read address valid
   output logic             s_axi_arready,        // read address ready
   output logic [31:0]      s_axi_rdata,          // read data
   output logic [1:0]       s_axi_rresp,          // read response
   output logic             s_axi_rvalid,         // read data valid
   input  wire logic        s_axi_rready,         // read data ready
   input  wire logic        optics_cdr_pin,       // optics clock recovery failed
   input  wire logic        optics_pwr_pin,       // optics receive power low
   input  wire logic        framer_nosig_pin,     // framer sees no signal
   input  wire logic        framer_noclk_pin,     // framer has no clock
   input  wire logic        framer_unlock_pin,    // framer out of frame
   input  wire logic        framer_noptr_pin,     // framer lost pointers
   input  wire logic        crc_fail_ev,          // frame failed CRC32
   input  wire logic        frame_ok_ev,          // frame received
   input  wire logic        rx_fifo_err_ev,       // framer rx FIFO error
   input  wire logic        tx_fifo_err_ev,       // framer tx FIFO error
   input  wire logic        section_bip_ev,       // section parity error
   input  wire logic        line_bip_ev,          // line parity error
   input  wire logic        path_bip_ev,          // path parity error
   input  wire logic        link_parity_ev,       // framer link parity error
   input  wire logic [7:0]  label_in,             // received path label octet
   output logic             optics_rx_alarm,      // optics summary alarm
   output logic             optics_cdr_fail,      // optics cdr failure
   output logic             optics_power_low,     // optics power low
   output logic             no_signal_flag,       // no receive signal
   output logic             recovered_clk_absent, // no recovered clock
   output logic             frame_unlocked,       // out of frame
   output logic             frame_sync_lost,      // out of frame too long
   output logic             pointer_lost,         // pointer lock lost
   output logic [7:0]       path_signal_label_octet, // label octet
   output logic             irq                   // unmasked sticky flag set
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic cnt_addr(input logic [7:0] a);
      cnt_addr = (a >= `SPRM_CNT_BASE_OFS) && (a <= `SPRM_CNT_LAST_OFS)
                 && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [2:0] cnt_index(input logic [7:0] a);
      logic [7:0] d;
      d = a - `SPRM_CNT_BASE_OFS;
      cnt_index = d[4:2];
   endfunction

   function automatic sprm_word_type sat_add(input sprm_word_type v,
                                             input logic e);
      sat_add = (e && (v != 32'hFFFFFFFF)) ? v + 32'h1 : v;
   endfunction

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [5:0]     pin_q1;
   logic [5:0]     pin_q2;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         pin_q1 <= 6'h00;
         pin_q2 <= 6'h00;
      end else begin
         pin_q1 <= {framer_noptr_pin, framer_unlock_pin, framer_noclk_pin,
                    framer_nosig_pin, optics_pwr_pin, optics_cdr_pin};
         pin_q2 <= pin_q1;
      end
   end

   assign optics_cdr_fail      = pin_q2[0];
   assign optics_power_low     = pin_q2[1];
   assign no_signal_flag       = pin_q2[2];
   assign recovered_clk_absent = pin_q2[3];
   assign frame_unlocked       = pin_q2[4];
   assign pointer_lost         = pin_q2[5];

   // summary derived from its causes so it never stands alone
   assign optics_rx_alarm = pin_q2[0] | pin_q2[1];

   // ------------------------------------------------------------
   // out-of-frame persistence timer
   // ------------------------------------------------------------
   logic [31:0]    unl_cnt;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         unl_cnt         <= 32'h0;
         frame_sync_lost <= 1'b0;
      end else if (!frame_unlocked) begin
         unl_cnt         <= 32'h0;
         frame_sync_lost <= 1'b0;
      end else if (unl_cnt == SYNC_LOSS_CYCLES) begin
         frame_sync_lost <= 1'b1;
      end else begin
         unl_cnt <= unl_cnt + 32'h1;
      end
   end

   // ------------------------------------------------------------
   // path label
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn) begin
         path_signal_label_octet <= 8'h00;
      end else begin
         path_signal_label_octet <= label_in;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   logic           aw_held;
   logic [7:0]     aw_addr;
   logic           w_held;
   logic [31:0]    w_data;
   logic [3:0]     w_strb;
   logic           wr_go;
   logic           wr_ok;

   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign wr_ok = (aw_addr == `SPRM_LIVE_OFS) || (aw_addr == `SPRM_STICKY_OFS)
                  || (aw_addr == `SPRM_MASK_OFS) || (aw_addr == `SPRM_LABEL_OFS)
                  || cnt_addr(aw_addr);

   always_ff @(posedge clock) begin
      if (!rstn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && !aw_held) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         w_held <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && !w_held) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SPRM_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? `SPRM_RESP_OKAY : `SPRM_RESP_SLV;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // flags, mask, interrupt
   // ------------------------------------------------------------
   sprm_flags_type live;
   sprm_flags_type sticky;
   sprm_flags_type mask;
   sprm_flags_type w1c;

   assign live = {pointer_lost, frame_sync_lost, frame_unlocked,
                  recovered_clk_absent, no_signal_flag, optics_power_low,
                  optics_cdr_fail, optics_rx_alarm};
   assign w1c = (wr_go && (aw_addr == `SPRM_STICKY_OFS) && w_strb[0])
                ? w_data[7:0] : 8'h00;

   // a flag still raised during its clear stays set, so no episode is lost
   always_ff @(posedge clock) begin
      if (!rstn) begin
         sticky <= 8'h00;
      end else begin
         sticky <= (sticky & ~w1c) | live;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         mask <= `SPRM_MASK_RST;
      end else if (wr_go && (aw_addr == `SPRM_MASK_OFS) && w_strb[0]) begin
         mask <= w_data[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(sticky & mask);
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel and clear-on-read counters
   // ------------------------------------------------------------
   sprm_word_type  cnt [8];
   logic [7:0]     ev;
   logic           rd_go;
   logic           rd_cnt;
   logic [2:0]     rd_idx;
   sprm_word_type  next_rdata;
   logic           rd_ok;

   assign ev = {link_parity_ev, path_bip_ev, line_bip_ev, section_bip_ev,
                tx_fifo_err_ev, rx_fifo_err_ev, frame_ok_ev, crc_fail_ev};
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_go  = s_axi_arvalid && !s_axi_rvalid;
   assign rd_cnt = rd_go && cnt_addr(s_axi_araddr);
   assign rd_idx = cnt_index(s_axi_araddr);

   always_comb begin
      next_rdata = 32'h0;
      rd_ok      = 1'b1;
      if (cnt_addr(s_axi_araddr)) begin
         next_rdata = cnt[rd_idx];
      end else begin
         case (s_axi_araddr)
            `SPRM_LIVE_OFS:   next_rdata = {24'h0, live};
            `SPRM_STICKY_OFS: next_rdata = {24'h0, sticky};
            `SPRM_MASK_OFS:   next_rdata = {24'h0, mask};
            `SPRM_LABEL_OFS:  next_rdata = {24'h0, path_signal_label_octet};
            default:          rd_ok = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `SPRM_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= rd_ok ? `SPRM_RESP_OKAY : `SPRM_RESP_SLV;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // an event in the read cycle seeds the fresh interval instead of vanishing
   always_ff @(posedge clock) begin
      for (int i = 0; i < 8; i++) begin
         if (!rstn) begin
            cnt[i] <= 32'h0;
         end else if (rd_cnt && (rd_idx == 3'(i))) begin
            cnt[i] <= {31'h0, ev[i]};
         end else begin
            cnt[i] <= sat_add(cnt[i], ev[i]);
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_rd_clear(int i);
      rd_cnt && (rd_idx == 3'(i));
   endsequence

   sequence s_rd_done;
      ##1 s_axi_rvalid;
   endsequence

   property p_count(int i);
      !(rd_cnt && (rd_idx == 3'(i))) && ev[i] && (cnt[i] != 32'hFFFFFFFF)
         |=> cnt[i] == $past(cnt[i]) + 32'h1;
   endproperty

   property p_clear(int i);
      s_rd_clear(i) |-> s_rd_done
         ##0 (s_axi_rdata == $past(cnt[i]) && cnt[i] == {31'h0, $past(ev[i])});
   endproperty

   a_sync_release: assert property (
      !frame_unlocked |=> !frame_sync_lost)
      else $error("sync lost held without unlock");
   a_sync_timing: assert property (
      $rose(frame_sync_lost) |-> $past(unl_cnt) == SYNC_LOSS_CYCLES)
      else $error("sync lost raised at wrong time");
   a_unlock_follow: assert property (
      frame_unlocked == $past(framer_unlock_pin, 2))
      else $error("unlock flag not following pin");
   a_ptr_follow: assert property (
      pointer_lost == $past(framer_noptr_pin, 2))
      else $error("pointer flag not following pin");
   a_nosig_follow: assert property (
      no_signal_flag == $past(framer_nosig_pin, 2))
      else $error("signal flag not following pin");
   a_noclk_follow: assert property (
      recovered_clk_absent == $past(framer_noclk_pin, 2))
      else $error("clock flag not following pin");
   a_alarm_cause: assert property (
      optics_rx_alarm |-> (optics_cdr_fail || optics_power_low))
      else $error("summary alarm without cause");
   a_cdr_follow: assert property (
      optics_cdr_fail == $past(optics_cdr_pin, 2))
      else $error("cdr flag not following pin");
   a_pwr_follow: assert property (
      optics_power_low == $past(optics_pwr_pin, 2))
      else $error("power flag not following pin");
   a_crc_count: assert property (p_count(0))
      else $error("crc count missed");
   a_good_count: assert property (p_count(1))
      else $error("good frame count missed");
   a_rxfifo_count: assert property (p_count(2))
      else $error("rx fifo count missed");
   a_txfifo_count: assert property (p_count(3))
      else $error("tx fifo count missed");
   a_sticky_hold: assert property (
      sticky[`SPRM_B_UNLOCKED] && !w1c[`SPRM_B_UNLOCKED]
         |=> sticky[`SPRM_B_UNLOCKED])
      else $error("sticky flag dropped");
   a_sec_count: assert property (p_count(4))
      else $error("section parity count missed");
   a_line_count: assert property (p_count(5))
      else $error("line parity count missed");
   a_path_count: assert property (p_count(6))
      else $error("path parity count missed");
   a_label_copy: assert property (
      ##1 path_signal_label_octet == $past(label_in))
      else $error("label not copied");
   a_link_count: assert property (p_count(7))
      else $error("link parity count missed");
   a_read_clear: assert property (p_clear(0))
      else $error("read did not clear crc count");
   a_cnt_saturate: assert property (
      cnt[1] == 32'hFFFFFFFF && !(rd_cnt && (rd_idx == 3'h1)) |=> cnt[1] == 32'hFFFFFFFF)
      else $error("counter wrapped");

endmodule
